// file: shared/tccu_pkg.sv
// Constants, register map and field layout of the timer compare/capture unit.
// Assumes a plain register port with one-cycle strobes and read data a cycle later.
// Behaviour
// - Run bit zero stops and clears counter
// - Counter wrap raises overflow interrupt
// - Match signal when running counter equals either compare
// - Double buffering off at reset, control bit
// - Running buffered copy on compare one match
// - Stopped counter takes compare writes directly
// - Two-bit field selects capture events
// - Writing zero to capture bit captures
// - Readback snapshots while running, holds when stopped
// - Either comparator match raises match interrupt
// - Matches and captures toggle flop, enabled
// - Flop command: 00 toggle, 01 set, 10 clear
// - Toggle flop drives timer output pin
// - Capture interrupts on each capture latch
// - Enabled DMA request on compare one match or capture
// - Compare one mask suppresses its DMA request
// - Event mode counts external rising edges
// - Pulse mode toggles on both matches
// - Clear-on-match resets counter at compare one
// - Prescaler run bit starts and stops prescaler
package tccu_pkg;

    // ************************************************************
    // Register offsets
    // ************************************************************
    localparam logic [7:0] TCCU_ADDR_ENABLE  = 8'h00;
    localparam logic [7:0] TCCU_ADDR_RUN     = 8'h04;
    localparam logic [7:0] TCCU_ADDR_CTRL    = 8'h08;
    localparam logic [7:0] TCCU_ADDR_MODE    = 8'h0C;
    localparam logic [7:0] TCCU_ADDR_FFCTRL  = 8'h10;
    localparam logic [7:0] TCCU_ADDR_STATUS  = 8'h14;
    localparam logic [7:0] TCCU_ADDR_MASK    = 8'h18;
    localparam logic [7:0] TCCU_ADDR_CMP0    = 8'h1C;
    localparam logic [7:0] TCCU_ADDR_CMP1    = 8'h20;
    localparam logic [7:0] TCCU_ADDR_READBK  = 8'h24;
    localparam logic [7:0] TCCU_ADDR_CAP0    = 8'h28;
    localparam logic [7:0] TCCU_ADDR_CAP1    = 8'h2C;
    localparam logic [7:0] TCCU_ADDR_DMA     = 8'h30;

    // ************************************************************
    // Field positions
    // ************************************************************
    localparam int TCCU_EN_BIT        = 7;
    localparam int TCCU_RUN_CNT_BIT   = 0;
    localparam int TCCU_RUN_PRE_BIT   = 2;
    localparam int TCCU_CR_WBF_BIT    = 7;
    localparam int TCCU_MOD_CLK_LSB   = 0;
    localparam int TCCU_MOD_CLE_BIT   = 3;
    localparam int TCCU_MOD_CPM_LSB   = 4;
    localparam int TCCU_MOD_SWCAP_BIT = 6;
    localparam int TCCU_FF_CMD_LSB    = 0;
    localparam int TCCU_FF_E0T1_BIT   = 2;
    localparam int TCCU_FF_E1T1_BIT   = 3;
    localparam int TCCU_FF_C0T1_BIT   = 4;
    localparam int TCCU_FF_C1T1_BIT   = 5;
    localparam int TCCU_IM_CMP1_BIT   = 1;

    // ************************************************************
    // Reset values and encodings
    // ************************************************************
    localparam logic [2:0] TCCU_CLK_EXTERNAL = 3'h0;
    localparam logic [1:0] TCCU_FF_TOGGLE    = 2'h0;
    localparam logic [1:0] TCCU_FF_SET       = 2'h1;
    localparam logic [1:0] TCCU_FF_CLEAR     = 2'h2;
    localparam logic [1:0] TCCU_CPM_OFF      = 2'h0;
    localparam logic [1:0] TCCU_CPM_RISE     = 2'h1;
    localparam logic [1:0] TCCU_CPM_BOTH     = 2'h2;
    localparam logic [1:0] TCCU_CPM_MATCH    = 2'h3;
    localparam logic [7:0] TCCU_MOD_RESET    = 8'h40;
    localparam logic [7:0] TCCU_FF_RESET     = 8'h03;
    localparam logic [3:0] TCCU_PRE_WIDTH    = 4'h8;

endpackage : tccu_pkg

// file: logic/tccu_top.sv
// Timer channel: 16-bit up-counter, two compares, two captures, toggle flop.
// Assumes pin inputs synchronous to clk_sys and a never-waiting register port.
`timescale 1ns/10ps
module tccu_top #(
    parameter int CNT_W = 16
) (
    input  wire logic             clk_sys,
    input  wire logic             arst_n,
    input  wire logic [7:0]       reg_addr,
    input  wire logic [31:0]      reg_wdata,
    input  wire logic             reg_wr,
    input  wire logic             reg_rd,
    output logic      [31:0]      reg_rdata,
    input  wire logic             external_input_pin,
    output logic                  timer_output_pin,
    output logic                  match_detect,
    output logic                  match_overflow_irq,
    output logic                  capture_zero_irq,
    output logic                  capture_one_irq,
    output logic      [2:0]       dma_req
);
    import tccu_pkg::*;

    // Counter must fit the 32-bit read port
    if (CNT_W < 2 || CNT_W > 32) begin : g_cnt_w_check
        $error("CNT_W out of range");
    end

    // ************************************************************
    // Registers
    // ************************************************************
    logic             en_q;
    logic             run_cnt_q;
    logic             run_pre_q;
    logic             wbf_q;
    logic [7:0]       mod_q;
    logic [5:2]       ffen_q;
    logic [1:0]       mask_q;
    logic [2:0]       dmaen_q;
    logic [CNT_W-1:0] cnt_q;
    logic [CNT_W-1:0] rg0_q;
    logic [CNT_W-1:0] rg1_q;
    logic [CNT_W-1:0] buf0_q;
    logic [CNT_W-1:0] buf1_q;
    logic [CNT_W-1:0] cap0_q;
    logic [CNT_W-1:0] cap1_q;
    logic [CNT_W-1:0] snap_q;
    logic [7:0]       pre_q;
    logic             ff_q;
    logic             pin_q;
    logic [2:0]       stat_q;

    logic             wr_en;
    logic             wr_run;
    logic             wr_ctrl;
    logic             wr_mod;
    logic             wr_ff;
    logic             wr_mask;
    logic             wr_cmp0;
    logic             wr_cmp1;
    logic             wr_dma;
    logic             wr_stat;
    logic             running;
    logic             tick;
    logic             pin_rise;
    logic             pin_fall;
    logic             match0;
    logic             match1;
    logic             ovf;
    logic             swcap;
    logic             cap0_ev;
    logic             cap1_ev;
    logic [2:0]       clk_sel;
    logic [1:0]       cpm;

    function automatic logic hit(input logic [7:0] a, input logic [7:0] b);
        hit = (a == b);
    endfunction : hit

    assign wr_en   = reg_wr && hit(reg_addr, TCCU_ADDR_ENABLE);
    assign wr_run  = reg_wr && hit(reg_addr, TCCU_ADDR_RUN);
    assign wr_ctrl = reg_wr && hit(reg_addr, TCCU_ADDR_CTRL);
    assign wr_mod  = reg_wr && hit(reg_addr, TCCU_ADDR_MODE);
    assign wr_ff   = reg_wr && hit(reg_addr, TCCU_ADDR_FFCTRL);
    assign wr_mask = reg_wr && hit(reg_addr, TCCU_ADDR_MASK);
    assign wr_cmp0 = reg_wr && hit(reg_addr, TCCU_ADDR_CMP0);
    assign wr_cmp1 = reg_wr && hit(reg_addr, TCCU_ADDR_CMP1);
    assign wr_dma  = reg_wr && hit(reg_addr, TCCU_ADDR_DMA);
    assign wr_stat = reg_wr && hit(reg_addr, TCCU_ADDR_STATUS);

    assign clk_sel = mod_q[TCCU_MOD_CLK_LSB +: 3];
    assign cpm     = mod_q[TCCU_MOD_CPM_LSB +: 2];
    assign running = en_q && run_cnt_q && run_pre_q;

    // ************************************************************
    // Control registers
    // ************************************************************
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            en_q      <= 1'b0;
            run_cnt_q <= 1'b0;
            run_pre_q <= 1'b0;
            wbf_q     <= 1'b0;
            mod_q     <= TCCU_MOD_RESET;
            ffen_q    <= TCCU_FF_RESET[5:2];
            mask_q    <= 2'h0;
            dmaen_q   <= 3'h0;
        end else begin
            if (wr_en) begin
                en_q <= reg_wdata[TCCU_EN_BIT];
            end
            if (wr_run) begin
                run_cnt_q <= reg_wdata[TCCU_RUN_CNT_BIT];
                run_pre_q <= reg_wdata[TCCU_RUN_PRE_BIT];
            end
            if (wr_ctrl) begin
                wbf_q <= reg_wdata[TCCU_CR_WBF_BIT];
            end
            if (wr_mod) begin
                mod_q <= reg_wdata[7:0];
            end
            if (wr_ff) begin
                ffen_q <= reg_wdata[5:2];
            end
            if (wr_mask) begin
                mask_q <= reg_wdata[1:0];
            end
            if (wr_dma) begin
                dmaen_q <= reg_wdata[2:0];
            end
        end
    end

    // ************************************************************
    // Prescaler and count source
    // ************************************************************
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            pre_q <= 8'h00;
            pin_q <= 1'b0;
        end else begin
            pin_q <= external_input_pin;
            if (!(en_q && run_pre_q)) begin
                pre_q <= 8'h00;
            end else begin
                pre_q <= pre_q + 8'h01;
            end
        end
    end

    assign pin_rise = external_input_pin && !pin_q;
    assign pin_fall = !external_input_pin && pin_q;

    // Prescaler taps: codes 1..7 divide by 1,4,16,32,64,128,256
    always_comb begin
        tick = 1'b0;
        unique case (clk_sel)
            TCCU_CLK_EXTERNAL: tick = pin_rise;
            3'h1:              tick = 1'b1;
            3'h2:              tick = (pre_q[1:0] == 2'h3);
            3'h3:              tick = (pre_q[3:0] == 4'hF);
            3'h4:              tick = (pre_q[4:0] == 5'h1F);
            3'h5:              tick = (pre_q[5:0] == 6'h3F);
            3'h6:              tick = (pre_q[6:0] == 7'h7F);
            3'h7:              tick = (pre_q == 8'hFF);
        endcase
    end

    // ************************************************************
    // Up-counter and comparators
    // ************************************************************
    // equality match detect
    assign match0       = running && (cnt_q == rg0_q);
    assign match1       = running && (cnt_q == rg1_q);
    assign match_detect = match0 || match1;
    assign ovf = running && tick && (cnt_q == {CNT_W{1'b1}});

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            cnt_q <= '0;
        end else if (!run_cnt_q || !en_q) begin
            cnt_q <= '0;
        end else if (running && tick) begin
            if (mod_q[TCCU_MOD_CLE_BIT] && (cnt_q == rg1_q)) begin
                cnt_q <= '0;
            end else begin
                cnt_q <= cnt_q + 1'b1;
            end
        end
    end

    // ************************************************************
    // Compare registers with double buffer
    // ************************************************************
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            rg0_q  <= '0;
            rg1_q  <= '1;
            buf0_q <= '0;
            buf1_q <= '1;
        end else begin
            if (wr_cmp0) begin
                buf0_q <= reg_wdata[CNT_W-1:0];
            end
            if (wr_cmp1) begin
                buf1_q <= reg_wdata[CNT_W-1:0];
            end
            if (!wbf_q || !running) begin
                if (wr_cmp0) begin
                    rg0_q <= reg_wdata[CNT_W-1:0];
                end
                if (wr_cmp1) begin
                    rg1_q <= reg_wdata[CNT_W-1:0];
                end
            end else if (match1 && tick) begin
                rg0_q <= buf0_q;
                rg1_q <= buf1_q;
            end
        end
    end

    // ************************************************************
    // Capture
    // ************************************************************
    // software capture on zero write
    assign swcap = wr_mod && !reg_wdata[TCCU_MOD_SWCAP_BIT];

    always_comb begin
        cap0_ev = swcap;
        cap1_ev = 1'b0;
        unique case (cpm)
            TCCU_CPM_OFF: begin
            end
            TCCU_CPM_RISE: begin
                cap0_ev = swcap || (running && pin_rise);
            end
            TCCU_CPM_BOTH: begin
                cap0_ev = swcap || (running && pin_rise);
                cap1_ev = running && pin_fall;
            end
            TCCU_CPM_MATCH: begin
                cap0_ev = swcap || (match1 && tick);
                cap1_ev = match0 && tick;
            end
        endcase
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            cap0_q <= '0;
            cap1_q <= '0;
        end else begin
            if (cap0_ev) begin
                cap0_q <= cnt_q;
            end
            if (cap1_ev) begin
                cap1_q <= cnt_q;
            end
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            snap_q <= '0;
        end else if (reg_rd && hit(reg_addr, TCCU_ADDR_READBK) && running) begin
            snap_q <= cnt_q;
        end
    end

    // ************************************************************
    // Timer toggle flop
    // ************************************************************
    logic ff_toggle;
    assign ff_toggle = (ffen_q[TCCU_FF_E0T1_BIT] && match0 && tick)
                    || (ffen_q[TCCU_FF_E1T1_BIT] && match1 && tick)
                    || (ffen_q[TCCU_FF_C0T1_BIT] && cap0_ev)
                    || (ffen_q[TCCU_FF_C1T1_BIT] && cap1_ev);

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            ff_q <= 1'b0;
        end else if (wr_ff) begin
            unique case (reg_wdata[TCCU_FF_CMD_LSB +: 2])
                TCCU_FF_TOGGLE: ff_q <= !ff_q;
                TCCU_FF_SET:    ff_q <= 1'b1;
                TCCU_FF_CLEAR:  ff_q <= 1'b0;
                default:        ff_q <= ff_toggle ? !ff_q : ff_q;
            endcase
        end else if (ff_toggle) begin
            ff_q <= !ff_q;
        end
    end

    assign timer_output_pin = ff_q;

    // ************************************************************
    // Interrupts, status and DMA
    // ************************************************************
    logic match_ev;
    assign match_ev = (match0 || match1) && tick;

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            match_overflow_irq <= 1'b0;
            capture_zero_irq   <= 1'b0;
            capture_one_irq    <= 1'b0;
            dma_req            <= 3'h0;
            stat_q             <= 3'h0;
        end else begin
            match_overflow_irq <= match_ev || ovf;
            capture_zero_irq   <= cap0_ev;
            capture_one_irq    <= cap1_ev;
            dma_req[0] <= dmaen_q[0] && cap0_ev;
            dma_req[1] <= dmaen_q[1] && cap1_ev;
            dma_req[2] <= dmaen_q[2] && match1 && tick && !mask_q[TCCU_IM_CMP1_BIT];
            // Set wins over write-one clear
            stat_q <= (stat_q & ~(wr_stat ? reg_wdata[2:0] : 3'h0))
                    | {ovf, cap0_ev || cap1_ev, match_ev};
        end
    end

    // ************************************************************
    // Read port
    // ************************************************************
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            reg_rdata <= 32'h0000_0000;
        end else if (reg_rd) begin
            reg_rdata <= 32'h0000_0000;
            unique case (reg_addr)
                TCCU_ADDR_ENABLE: reg_rdata[TCCU_EN_BIT] <= en_q;
                TCCU_ADDR_RUN: begin
                    reg_rdata[TCCU_RUN_CNT_BIT] <= run_cnt_q;
                    reg_rdata[TCCU_RUN_PRE_BIT] <= run_pre_q;
                end
                TCCU_ADDR_CTRL:   reg_rdata[TCCU_CR_WBF_BIT] <= wbf_q;
                TCCU_ADDR_MODE:   reg_rdata[7:0] <= mod_q;
                TCCU_ADDR_FFCTRL: reg_rdata[7:0] <= {2'h0, ffen_q, 2'h3};
                TCCU_ADDR_STATUS: reg_rdata[2:0] <= stat_q;
                TCCU_ADDR_MASK:   reg_rdata[1:0] <= mask_q;
                TCCU_ADDR_CMP0:   reg_rdata[CNT_W-1:0] <= rg0_q;
                TCCU_ADDR_CMP1:   reg_rdata[CNT_W-1:0] <= rg1_q;
                TCCU_ADDR_READBK: reg_rdata[CNT_W-1:0] <= running ? cnt_q : snap_q;
                TCCU_ADDR_CAP0:   reg_rdata[CNT_W-1:0] <= cap0_q;
                TCCU_ADDR_CAP1:   reg_rdata[CNT_W-1:0] <= cap1_q;
                TCCU_ADDR_DMA:    reg_rdata[2:0] <= dmaen_q;
                default:          reg_rdata <= 32'h0000_0000;
            endcase
        end else begin
            reg_rdata <= 32'h0000_0000;
        end
    end

endmodule : tccu_top

// file: verification/tccu_props.sv
// Port-level checks for the timer compare/capture channel.
// Bound to tccu_top from the bench; sees only its ports.
`timescale 1ns/10ps
module tccu_props
    import tccu_pkg::*;
(
    input wire logic        clk_sys,
    input wire logic        arst_n,
    input wire logic [7:0]  reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic        reg_wr,
    input wire logic        match_detect,
    input wire logic        timer_output_pin,
    input wire logic        match_overflow_irq,
    input wire logic        capture_zero_irq,
    input wire logic        capture_one_irq,
    input wire logic [2:0]  dma_req
);
    logic mask_q;
    logic ff_wr;
    logic mode_wr;
    assign ff_wr   = reg_wr && reg_addr == TCCU_ADDR_FFCTRL;
    assign mode_wr = reg_wr && reg_addr == TCCU_ADDR_MODE;

    // Mirror of the compare-one mask bit
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            mask_q <= 1'b0;
        end else if (reg_wr && reg_addr == TCCU_ADDR_MASK) begin
            mask_q <= reg_wdata[TCCU_IM_CMP1_BIT];
        end
    end

    default clocking dc @(posedge clk_sys); endclocking
    default disable iff (!arst_n);

    // ****************
    // Assertions
    // ****************
    a_run_stop: assert property (
        reg_wr && reg_addr == TCCU_ADDR_RUN && !reg_wdata[TCCU_RUN_CNT_BIT]
        |=> !match_detect [*3]) else $error("match seen after stop");
    a_ff_set: assert property (
        ff_wr && reg_wdata[1:0] == TCCU_FF_SET |=> timer_output_pin)
        else $error("flop not set");
    a_ff_clear: assert property (
        ff_wr && reg_wdata[1:0] == TCCU_FF_CLEAR |=> !timer_output_pin)
        else $error("flop not cleared");
    a_ff_toggle: assert property (
        ff_wr && reg_wdata[1:0] == TCCU_FF_TOGGLE
        |=> timer_output_pin != $past(timer_output_pin))
        else $error("flop not toggled");
    a_dma_mask: assert property (dma_req[2] |-> !$past(mask_q))
        else $error("masked dma request");
    a_dma_cap0: assert property (dma_req[0] |-> capture_zero_irq)
        else $error("dma0 without capture");
    a_dma_cap1: assert property (dma_req[1] |-> capture_one_irq)
        else $error("dma1 without capture");
    a_dma_match: assert property (dma_req[2] |-> match_overflow_irq)
        else $error("dma2 without match");
    a_sw_capture: assert property (
        mode_wr && !reg_wdata[TCCU_MOD_SWCAP_BIT] |-> ##[1:3] capture_zero_irq)
        else $error("no software capture");

    c_cap1: cover property (capture_one_irq);
    c_dma2: cover property (dma_req[2]);
    c_match: cover property (match_detect ##1 match_overflow_irq);
endmodule : tccu_props

// file: verification/tccu_pin_partner.sv
// Far side model: drives the event pin, counts output pin edges.
// Assumes the bench pulses go for one cycle while busy is low.
`timescale 1ns/10ps
module tccu_pin_partner (
    input  wire logic        clk_sys,
    input  wire logic        arst_n,
    input  wire logic        go,
    input  wire logic [3:0]  edge_num,
    input  wire logic [2:0]  half_len,
    output logic             busy,
    output logic             external_input_pin,
    input  wire logic        timer_output_pin,
    output logic [15:0]      toggle_count
);
    logic [4:0] phase_q;
    logic [2:0] wait_q;
    logic       last_q;
    assign busy = phase_q != 5'h0;

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            phase_q            <= 5'h0;
            wait_q             <= 3'h0;
            external_input_pin <= 1'b0;
        end else if (go && !busy) begin
            phase_q <= {edge_num, 1'b0};
            wait_q  <= half_len;
        end else if (busy && wait_q == 3'h0) begin
            external_input_pin <= ~external_input_pin;
            phase_q            <= phase_q - 5'h1;
            wait_q             <= half_len;
        end else if (busy) begin
            wait_q <= wait_q - 3'h1;
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            last_q       <= 1'b0;
            toggle_count <= 16'h0;
        end else begin
            last_q <= timer_output_pin;
            if (last_q != timer_output_pin) begin
                toggle_count <= toggle_count + 16'h1;
            end
        end
    end
endmodule : tccu_pin_partner

// file: verification/tccu_bench.sv
// Self-checking bench for the timer compare/capture channel.
// Assumes /1 source ticks once per clk_sys cycle.
`timescale 1ns/10ps
module tccu_bench;
    import tccu_pkg::*;
    logic        clk_sys, arst_n, reg_wr, reg_rd, ext_pin, tout;
    logic [7:0]  reg_addr;
    logic [31:0] reg_wdata, reg_rdata;
    logic        mdet, mirq, cap0_irq, cap1_irq, go, busy, rd_seen;
    logic [2:0]  dma_req, half_len;
    logic [3:0]  edge_num;
    logic [15:0] toggle_count;
    logic [31:0] exp_q[$];
    logic [1:0]  ff_cmd[5] = '{2'h1, 2'h2, 2'h0, 2'h3, 2'h0};
    logic        ff_exp[5] = '{1'b1, 1'b0, 1'b1, 1'b1, 1'b0};
    int          bad_count, check_count, cap0_cnt, cap1_cnt, mirq_cnt, dma_cnt[3];
    int          n, m, t0, mdet_cnt;

    tccu_top DUT (.clk_sys(clk_sys), .arst_n(arst_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .external_input_pin(ext_pin), .timer_output_pin(tout), .match_detect(mdet),
        .match_overflow_irq(mirq), .capture_zero_irq(cap0_irq),
        .capture_one_irq(cap1_irq), .dma_req(dma_req));
    tccu_pin_partner u_pin (.clk_sys(clk_sys), .arst_n(arst_n), .go(go),
        .edge_num(edge_num), .half_len(half_len), .busy(busy),
        .external_input_pin(ext_pin), .timer_output_pin(tout),
        .toggle_count(toggle_count));

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            bad_count++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        exp_q.push_back(e);
        @(posedge clk_sys);
        reg_rd <= 1'b0;
    endtask : rd
    task automatic pulses(input int k);
        @(posedge clk_sys);
        edge_num <= 4'(k);
        half_len <= 3'($urandom_range(1, 4));
        go       <= 1'b1;
        @(posedge clk_sys);
        go <= 1'b0;
        @(posedge clk_sys);
        while (busy === 1'b1) @(posedge clk_sys);
        repeat (4) @(posedge clk_sys);
    endtask : pulses
    task automatic finish_test();
        if (bad_count == 0 && check_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : finish_test

    // Read results and pulse counts
    always @(posedge clk_sys) begin
        if (rd_seen === 1'b1 && exp_q.size() > 0) begin
            check(reg_rdata, exp_q.pop_front());
        end
        rd_seen <= reg_rd;
        cap0_cnt += (cap0_irq === 1'b1);
        cap1_cnt += (cap1_irq === 1'b1);
        mirq_cnt += (mirq === 1'b1);
        mdet_cnt += (mdet === 1'b1);
        foreach (dma_cnt[i]) dma_cnt[i] += (dma_req[i] === 1'b1);
    end
    initial begin
        clk_sys = 1'b0;
        forever #20 clk_sys = ~clk_sys;
    end
    initial begin
        repeat (90000) @(posedge clk_sys);
        bad_count++;
        finish_test();
    end

    initial begin
        {arst_n, reg_wr, reg_rd, go, rd_seen} = 5'h0;
        {reg_addr, reg_wdata, edge_num, half_len} = 47'h0;
        void'($urandom(32'hF8F8));
        repeat (10) @(posedge clk_sys);
        arst_n <= 1'b1;
        rd(TCCU_ADDR_MODE, 32'h40);
        rd(TCCU_ADDR_CTRL, 32'h0);
        rd(TCCU_ADDR_CMP1, 32'hFFFF);
        rd(TCCU_ADDR_FFCTRL, 32'h3);
        rd(8'hFC, 32'h0);
        wr(TCCU_ADDR_ENABLE, 32'h80);
        foreach (ff_cmd[i]) begin
            wr(TCCU_ADDR_FFCTRL, {30'h0, ff_cmd[i]});
            repeat (2) @(posedge clk_sys);
            check({31'h0, tout}, {31'h0, ff_exp[i]});
        end
        n = $urandom_range(1, 8);
        m = $urandom_range(1, 8);
        wr(TCCU_ADDR_MODE, 32'h40);
        wr(TCCU_ADDR_RUN, 32'h5);
        pulses(n);
        wr(TCCU_ADDR_MODE, 32'h00);
        rd(TCCU_ADDR_CAP0, 32'(n));
        rd(TCCU_ADDR_READBK, 32'(n));
        wr(TCCU_ADDR_RUN, 32'h0);
        rd(TCCU_ADDR_READBK, 32'(n));
        wr(TCCU_ADDR_MODE, 32'h40);
        wr(TCCU_ADDR_RUN, 32'h5);
        pulses(m);
        wr(TCCU_ADDR_MODE, 32'h00);
        rd(TCCU_ADDR_CAP0, 32'(m));
        // stopped setup, compare zero below one
        wr(TCCU_ADDR_RUN, 32'h0);
        wr(TCCU_ADDR_CTRL, 32'h80);
        wr(TCCU_ADDR_CMP0, 32'h3);
        wr(TCCU_ADDR_CMP1, 32'h7);
        rd(TCCU_ADDR_CMP1, 32'h7);
        wr(TCCU_ADDR_FFCTRL, 32'h0E);
        wr(TCCU_ADDR_MASK, 32'h2);
        wr(TCCU_ADDR_DMA, 32'h4);
        wr(TCCU_ADDR_MODE, 32'h49);
        t0 = toggle_count;
        dma_cnt[2] = 0;
        mdet_cnt = 0;
        wr(TCCU_ADDR_RUN, 32'h5);
        repeat (80) @(posedge clk_sys);
        check(32'(toggle_count - t0 inside {[18:22]}), 32'h1);
        check(32'(dma_cnt[2]), 32'h0);
        check(32'(mdet_cnt inside {[18:22]}), 32'h1);
        wr(TCCU_ADDR_CMP0, 32'h5);
        wr(TCCU_ADDR_CMP1, 32'hF);
        wr(TCCU_ADDR_MASK, 32'h0);
        repeat (20) @(posedge clk_sys);
        t0 = toggle_count;
        repeat (96) @(posedge clk_sys);
        check(32'(toggle_count - t0 inside {[10:13]}), 32'h1);
        check(32'(dma_cnt[2] > 0 && mirq_cnt > 0), 32'h1);
        wr(TCCU_ADDR_DMA, 32'h3);
        for (int c = 1; c < 4; c++) begin
            {cap0_cnt, cap1_cnt, dma_cnt[0], dma_cnt[1]} = 128'h0;
            wr(TCCU_ADDR_MODE, 32'h49 | 32'(c << 4));
            pulses(3);
            wr(TCCU_ADDR_MODE, 32'h49);
            repeat (4) @(posedge clk_sys);
            check(32'(cap0_cnt > 0), 32'h1);
            check(32'(cap1_cnt > 0), 32'(c != 1));
            check(32'(dma_cnt[0]), 32'(cap0_cnt));
            check(32'(dma_cnt[1]), 32'(cap1_cnt));
        end
        wr(TCCU_ADDR_RUN, 32'h0);
        wr(TCCU_ADDR_CTRL, 32'h0);
        wr(TCCU_ADDR_CMP0, 32'h0);
        wr(TCCU_ADDR_CMP1, 32'hFFFF);
        wr(TCCU_ADDR_MODE, 32'h41);
        wr(TCCU_ADDR_STATUS, 32'h7);
        rd(TCCU_ADDR_STATUS, 32'h0);
        wr(TCCU_ADDR_RUN, 32'h5);
        repeat (65560) @(posedge clk_sys);
        wr(TCCU_ADDR_RUN, 32'h0);
        rd(TCCU_ADDR_STATUS, 32'h5);
        repeat (3) @(posedge clk_sys);
        finish_test();
    end
endmodule : tccu_bench

bind tccu_top tccu_props u_props (.clk_sys(clk_sys), .arst_n(arst_n),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .match_detect(match_detect), .timer_output_pin(timer_output_pin),
    .match_overflow_irq(match_overflow_irq), .capture_zero_irq(capture_zero_irq),
    .capture_one_irq(capture_one_irq), .dma_req(dma_req));
